// >>> common/scsc_pkg.sv
package scsc_pkg;

    // ==========================================================
    // Clock modes, as coded in the three-bit strap field
    typedef enum logic [2:0] {
        LOW_POWER_CRYSTAL_MODE = 3'h0,
        MEDIUM_GAIN_CRYSTAL_MODE = 3'h1,
        HIGH_GAIN_CRYSTAL_MODE = 3'h2,
        EXT_RC_MODE = 3'h3,
        INTERNAL_OSC_BLOCK = 3'h4,
        EXT_CLOCK_LOW_POWER = 3'h5,
        EXT_CLOCK_MEDIUM_POWER = 3'h6,
        EXT_CLOCK_HIGH_POWER = 3'h7
    } scsc_mode_t;

    // Power or gain setting handed to the pad
    typedef enum logic [1:0] {
        SCSC_PWR_LOW = 2'h0,
        SCSC_PWR_MED = 2'h1,
        SCSC_PWR_HIGH = 2'h2
    } scsc_power_t;

    // Internal sources of the oscillator block
    typedef enum logic [1:0] {
        SCSC_INTERNAL_LOW_FREQ_SOURCE = 2'h0,
        SCSC_INTERNAL_MID_FREQ_SOURCE = 2'h1,
        SCSC_INTERNAL_HIGH_FREQ_SOURCE = 2'h2
    } scsc_int_src_t;

    // Control flow, one-hot
    typedef enum logic [4:0] {
        ST_CAPTURE = 5'h01,
        ST_STARTUP = 5'h02,
        ST_EXTERNAL = 5'h04,
        ST_INTERNAL = 5'h08,
        ST_FAILED = 5'h10
    } scsc_state_t;

    // ==========================================================
    // Register map and fields
    localparam logic [3:0] SCSC_REG_CONTROL = 4'h0;
    localparam logic [3:0] SCSC_REG_STATUS = 4'h1;
    localparam logic [3:0] SCSC_REG_TRIM = 4'h2;
    localparam logic [3:0] SCSC_REG_FAIL = 4'h3;
    localparam int SCSC_CTL_PLL_BIT = 7;
    localparam int SCSC_CTL_FREQ_LSB = 3;
    localparam int SCSC_CTL_SRC_LSB = 0;
    localparam int SCSC_FAIL_FLAG_BIT = 0;
    localparam int SCSC_FAIL_EN_BIT = 1;
    localparam logic [3:0] SCSC_FREQ_RESET = 4'h7;
    localparam logic [3:0] SCSC_FREQ_HF_MIN = 4'h8;
    localparam logic [5:0] SCSC_TRIM_RESET = 6'h00;
    localparam int SCSC_SYNC_DEPTH = 2;

    // ==========================================================
    // Timing
    localparam int SCSC_CLK_PERIOD_NS = 8;
    localparam int SCSC_OST_PERIODS = 1024;
    localparam int SCSC_FAIL_TIME_NS = 20000;
    localparam int SCSC_FAIL_CYCLES =
        (SCSC_FAIL_TIME_NS + SCSC_CLK_PERIOD_NS - 1) / SCSC_CLK_PERIOD_NS;
    localparam int SCSC_EDGE_W = 11;
    localparam int SCSC_QUIET_W = 12;

    // ==========================================================
    // Carriers
    typedef struct packed {
        scsc_mode_t mode;
        logic two_speed;
        logic fail_safe;
        logic clock_out_pin_function;
    } scsc_straps_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } scsc_bus_req_t;

    typedef struct packed {
        logic use_internal;
        logic hold_clock;
        scsc_int_src_t int_source;
        logic pll_on;
        logic crystal_drive;
        scsc_power_t power;
        logic clock_out_pin_function_en;
        logic [5:0] trim;
    } scsc_clk_ctl_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [SCSC_EDGE_W-1:0] edges;
        logic [SCSC_QUIET_W-1:0] quiet;
        logic done;
        logic lost;
    } scsc_watch_st_t;

    typedef struct packed {
        scsc_state_t state;
        logic [1:0] cap_cnt;
        scsc_straps_t strap_s1;
        scsc_straps_t strap_s2;
        scsc_straps_t cfg;
        logic pll_en;
        logic [3:0] freq_code;
        logic [1:0] src_sel;
        logic [5:0] trim;
        logic fail_flag;
        logic fail_en;
        logic fail_req;
        logic restart;
        logic [7:0] rd_data;
        scsc_clk_ctl_t ctl;
    } scsc_main_st_t;

    // ==========================================================
    // Mode decoding
    function automatic logic scsc_is_crystal(input scsc_mode_t m);
        return m == LOW_POWER_CRYSTAL_MODE || m == MEDIUM_GAIN_CRYSTAL_MODE
            || m == HIGH_GAIN_CRYSTAL_MODE;
    endfunction : scsc_is_crystal

    function automatic logic scsc_uses_external(input scsc_mode_t m);
        return m != INTERNAL_OSC_BLOCK;
    endfunction : scsc_uses_external

    function automatic scsc_int_src_t scsc_freq_source(input logic [3:0] code);
        if (code == 4'h0) begin
            return SCSC_INTERNAL_LOW_FREQ_SOURCE;
        end else if (code < SCSC_FREQ_HF_MIN) begin
            return SCSC_INTERNAL_MID_FREQ_SOURCE;
        end
        return SCSC_INTERNAL_HIGH_FREQ_SOURCE;
    endfunction : scsc_freq_source

endpackage : scsc_pkg

// >>> hw/scsc_osc_watch.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// External oscillator watcher: start-up count and loss detect
module scsc_osc_watch
    import scsc_pkg::*;
#(
    parameter int START_PERIODS = SCSC_OST_PERIODS,
    parameter int FAIL_CYCLES = SCSC_FAIL_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Oscillator pin and restart pulse
    input wire logic ext_clk_pin,
    input wire logic restart,
    // Status levels
    output logic ost_done,
    output logic clk_lost
);
    scsc_watch_st_t s;
    scsc_watch_st_t next_s;

    // Edge counting; only the second sync stage feeds the detector
    always_comb begin
        next_s = s;
        next_s.sync1 = ext_clk_pin;
        next_s.sync2 = s.sync1;
        next_s.prev = s.sync2;
        if (restart) begin
            next_s.edges = '0;
            next_s.quiet = '0;
            next_s.done = 1'b0;
            next_s.lost = 1'b0;
        end else if (s.sync2 && !s.prev) begin
            next_s.quiet = '0;
            next_s.lost = 1'b0;
            if (!s.done) begin
                next_s.edges = s.edges + 1'b1;
                next_s.done = s.edges == SCSC_EDGE_W'(START_PERIODS - 1);
            end
        end else if (s.quiet >= SCSC_QUIET_W'(FAIL_CYCLES)) begin
            // A slow edge stays under the limit; silence this long is loss
            next_s.lost = 1'b1;
        end else begin
            next_s.quiet = s.quiet + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign ost_done = s.done;
    assign clk_lost = s.lost;

endmodule : scsc_osc_watch
`default_nettype wire

// >>> hw/scsc_clock_control.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// System clock source control
module scsc_clock_control
    import scsc_pkg::*;
#(
    parameter int START_PERIODS = SCSC_OST_PERIODS,
    parameter int FAIL_CYCLES = SCSC_FAIL_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Configuration straps and oscillator pin
    input wire scsc_straps_t straps,
    input wire logic ext_clk_pin,
    // Register port
    input wire scsc_bus_req_t bus,
    output logic [7:0] rd_data,
    // Clock tree control
    output scsc_clk_ctl_t clk_ctl,
    output logic osc_fail_request
);
    scsc_main_st_t s;
    scsc_main_st_t next_s;
    logic ost_done;
    logic clk_lost;
    logic sw_internal;
    logic watching;

    // ==========================================================
    // Oscillator watcher
    scsc_osc_watch #(
        .START_PERIODS(START_PERIODS),
        .FAIL_CYCLES(FAIL_CYCLES)
    ) u_watch (
        .clk(clk),
        .reset(reset),
        .ext_clk_pin(ext_clk_pin),
        .restart(s.restart),
        .ost_done(ost_done),
        .clk_lost(clk_lost)
    );

    // Software forces the internal block when the top select bit is set
    assign sw_internal = s.src_sel[1];
    // Monitor only while the external source is in use, or while it starts up under two-speed start
    assign watching = s.cfg.fail_safe && !sw_internal
        && (s.state == ST_EXTERNAL || (s.state == ST_STARTUP && s.cfg.two_speed));

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.strap_s1 = straps;
        next_s.strap_s2 = s.strap_s1;
        next_s.restart = 1'b0;
        next_s.rd_data = 8'h00;

        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                SCSC_REG_CONTROL: begin
                    next_s.pll_en = bus.wdata[SCSC_CTL_PLL_BIT];
                    next_s.freq_code = bus.wdata[SCSC_CTL_FREQ_LSB +: 4];
                    next_s.src_sel = bus.wdata[SCSC_CTL_SRC_LSB +: 2];
                end
                SCSC_REG_TRIM: begin
                    next_s.trim = bus.wdata[5:0];
                end
                SCSC_REG_FAIL: begin
                    next_s.fail_en = bus.wdata[SCSC_FAIL_EN_BIT];
                    if (bus.wdata[SCSC_FAIL_FLAG_BIT]) begin
                        next_s.fail_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads, data valid in the following cycle only
        if (bus.rd) begin
            case (bus.addr)
                SCSC_REG_CONTROL: begin
                    next_s.rd_data = {s.pll_en, s.freq_code, 1'b0, s.src_sel};
                end
                SCSC_REG_STATUS: begin
                    next_s.rd_data = {s.cfg.mode, ost_done, clk_lost,
                        s.state == ST_FAILED, s.ctl.use_internal, s.ctl.hold_clock};
                end
                SCSC_REG_TRIM: begin
                    next_s.rd_data = {2'b00, s.trim};
                end
                SCSC_REG_FAIL: begin
                    next_s.rd_data = {6'h00, s.fail_en, s.fail_flag};
                end
                default: begin
                    next_s.rd_data = 8'h00;
                end
            endcase
        end

        // Control flow
        case (s.state)
            ST_CAPTURE: begin
                // Straps are caught only once the synchroniser has filled
                next_s.cap_cnt = s.cap_cnt + 1'b1;
                if (s.cap_cnt == 2'(SCSC_SYNC_DEPTH)) begin
                    next_s.cfg = s.strap_s2;
                    next_s.restart = 1'b1;
                    next_s.state = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                if (!scsc_uses_external(s.cfg.mode)) begin
                    next_s.state = ST_INTERNAL;
                end else if (watching && clk_lost) begin
                    next_s.state = ST_FAILED;
                end else if (!scsc_is_crystal(s.cfg.mode) || ost_done) begin
                    next_s.state = ST_EXTERNAL;
                end
            end
            ST_EXTERNAL: begin
                if (watching && clk_lost) begin
                    next_s.state = ST_FAILED;
                end
            end
            ST_INTERNAL: begin
                next_s.state = ST_INTERNAL;
            end
            ST_FAILED: begin
                // Leave only once software has seen the flag and a clock is back
                if (!s.fail_flag && !clk_lost) begin
                    next_s.restart = 1'b1;
                    next_s.state = ST_STARTUP;
                end
            end
            default: begin
                next_s.state = ST_CAPTURE;
            end
        endcase

        // Failure flag; the set wins over a clear in the same cycle
        if (watching && clk_lost) begin
            next_s.fail_flag = 1'b1;
        end
        next_s.fail_req = next_s.fail_flag && next_s.fail_en;

        // Clock tree outputs, registered together with the state
        next_s.ctl.use_internal = next_s.state != ST_EXTERNAL
            || next_s.src_sel[1];
        next_s.ctl.hold_clock = next_s.state == ST_CAPTURE
            || (next_s.state == ST_STARTUP && !next_s.cfg.two_speed);
        next_s.ctl.int_source = scsc_freq_source(next_s.freq_code);
        next_s.ctl.pll_on = next_s.pll_en && next_s.ctl.use_internal
            && next_s.ctl.int_source == SCSC_INTERNAL_HIGH_FREQ_SOURCE;
        next_s.ctl.crystal_drive = next_s.state != ST_CAPTURE
            && scsc_is_crystal(next_s.cfg.mode);
        next_s.ctl.clock_out_pin_function_en = next_s.state != ST_CAPTURE && next_s.cfg.clock_out_pin_function
            && !scsc_is_crystal(next_s.cfg.mode);
        next_s.ctl.trim = next_s.trim;
        case (next_s.cfg.mode)
            EXT_CLOCK_LOW_POWER, LOW_POWER_CRYSTAL_MODE: begin
                next_s.ctl.power = SCSC_PWR_LOW;
            end
            EXT_CLOCK_MEDIUM_POWER, MEDIUM_GAIN_CRYSTAL_MODE: begin
                next_s.ctl.power = SCSC_PWR_MED;
            end
            EXT_CLOCK_HIGH_POWER, HIGH_GAIN_CRYSTAL_MODE: begin
                next_s.ctl.power = SCSC_PWR_HIGH;
            end
            default: begin
                next_s.ctl.power = SCSC_PWR_LOW;
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
            s.state <= ST_CAPTURE;
            s.freq_code <= SCSC_FREQ_RESET;
            s.trim <= SCSC_TRIM_RESET;
            s.ctl.use_internal <= 1'b1;
            s.ctl.hold_clock <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign rd_data = s.rd_data;
    assign clk_ctl = s.ctl;
    assign osc_fail_request = s.fail_req;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    strap_capture_a: assert property (
        s.state == ST_CAPTURE ##1 s.state == ST_STARTUP |-> s.cfg == $past(s.strap_s2))
        else $error("mode not caught from synchronised straps");

    power_setting_a: assert property (
        s.state != ST_CAPTURE && s.cfg.mode == EXT_CLOCK_HIGH_POWER
        |-> s.ctl.power == SCSC_PWR_HIGH)
        else $error("high power external mode not driven high");

    no_drive_ec_a: assert property (
        !scsc_is_crystal(s.cfg.mode) |-> !s.ctl.crystal_drive)
        else $error("crystal driver on outside crystal modes");

    pll_source_a: assert property (
        s.ctl.pll_on |-> s.ctl.use_internal
        && s.ctl.int_source == SCSC_INTERNAL_HIGH_FREQ_SOURCE)
        else $error("pll on without high frequency internal source");

    sw_select_a: assert property (
        bus.wr && bus.addr == SCSC_REG_CONTROL && bus.wdata[1] |=> s.ctl.use_internal)
        else $error("software select to internal ignored");

    two_speed_a: assert property (
        s.state == ST_STARTUP && s.cfg.two_speed |-> s.ctl.use_internal && !s.ctl.hold_clock)
        else $error("two-speed start not running on internal");

    startup_hold_a: assert property (
        s.state == ST_STARTUP && scsc_is_crystal(s.cfg.mode) && !ost_done
        |=> s.state != ST_EXTERNAL)
        else $error("crystal used before start-up count");

    fail_switch_a: assert property (
        watching && clk_lost |=> s.state == ST_FAILED && s.ctl.use_internal && s.fail_flag)
        else $error("clock loss not handled");

    trim_read_a: assert property (
        bus.rd && bus.addr == SCSC_REG_TRIM |=> rd_data == {2'b00, $past(s.trim)})
        else $error("trim read back wrong");

    no_clock_out_pin_function_a: assert property (
        scsc_is_crystal(s.cfg.mode) |-> !s.ctl.clock_out_pin_function_en)
        else $error("clock out active in crystal mode");

    fail_request_a: assert property (
        s.fail_flag && s.fail_en && !(bus.wr && bus.addr == SCSC_REG_FAIL)
        |=> osc_fail_request && s.fail_flag)
        else $error("fail request not held");

    // Writes can only clear the flag; with no flag and no detected loss the request stays low
    fail_quiet_a: assert property (
        !s.fail_flag && !(watching && clk_lost) |=> !osc_fail_request)
        else $error("fail request without a flag");

    fail_clear_a: assert property (
        bus.wr && bus.addr == SCSC_REG_FAIL && bus.wdata[SCSC_FAIL_FLAG_BIT]
        && !(watching && clk_lost) |=> !s.fail_flag)
        else $error("fail flag not cleared by software");

    // ==========================================================
    // Mode decode and clock tree levels
    // Clock stays gated and internal until the mode is known
    capture_hold_a: assert property (
        s.state == ST_CAPTURE |-> s.ctl.hold_clock && s.ctl.use_internal)
        else $error("clock released before the straps were caught");

    power_low_a: assert property (
        s.state != ST_CAPTURE && s.cfg.mode == EXT_CLOCK_LOW_POWER
        |-> s.ctl.power == SCSC_PWR_LOW)
        else $error("low power external mode not driven low");

    power_medium_a: assert property (
        s.state != ST_CAPTURE && s.cfg.mode == EXT_CLOCK_MEDIUM_POWER
        |-> s.ctl.power == SCSC_PWR_MED)
        else $error("medium power external mode not driven medium");

    crystal_drive_a: assert property (
        s.state != ST_CAPTURE && scsc_is_crystal(s.cfg.mode) |-> s.ctl.crystal_drive)
        else $error("crystal driver off in a crystal mode");

    gain_high_a: assert property (
        s.state != ST_CAPTURE && s.cfg.mode == HIGH_GAIN_CRYSTAL_MODE
        |-> s.ctl.power == SCSC_PWR_HIGH)
        else $error("high gain crystal mode not driven high");

    int_low_a: assert property (
        bus.wr && bus.addr == SCSC_REG_CONTROL
        && bus.wdata[SCSC_CTL_FREQ_LSB +: 4] == 4'h0
        |=> s.ctl.int_source == SCSC_INTERNAL_LOW_FREQ_SOURCE)
        else $error("speed code zero not on the low frequency source");

    internal_mode_a: assert property (
        s.state == ST_INTERNAL
        |-> s.ctl.use_internal && !s.ctl.hold_clock && !s.ctl.crystal_drive)
        else $error("internal mode not running on the internal block");

    // Non-crystal external sources skip the start-up count entirely
    ext_direct_a: assert property (
        s.state == ST_STARTUP && !scsc_is_crystal(s.cfg.mode)
        && scsc_uses_external(s.cfg.mode) && !(watching && clk_lost)
        |=> s.state == ST_EXTERNAL)
        else $error("external clock held by the start-up count");

    fail_stay_a: assert property (
        s.state == ST_FAILED && s.fail_flag |=> s.state == ST_FAILED)
        else $error("failure left before software saw the flag");

    failed_internal_a: assert property (
        s.state == ST_FAILED |-> s.ctl.use_internal && !s.ctl.hold_clock)
        else $error("no internal clock after a failure");

    trim_out_a: assert property (
        bus.wr && bus.addr == SCSC_REG_TRIM |=> s.ctl.trim == $past(bus.wdata[5:0]))
        else $error("trim not passed to the oscillator");

    clock_out_pin_function_other_a: assert property (
        s.state != ST_CAPTURE && !scsc_is_crystal(s.cfg.mode) && s.cfg.clock_out_pin_function
        |-> s.ctl.clock_out_pin_function_en)
        else $error("clock out missing outside crystal modes");

    // ==========================================================
    // Main scenarios
    two_speed_c: cover property (
        s.state == ST_STARTUP && s.cfg.two_speed ##1 s.state == ST_EXTERNAL);
    internal_mode_c: cover property (s.state == ST_STARTUP ##1 s.state == ST_INTERNAL);
    crystal_start_c: cover property (
        s.state == ST_STARTUP && scsc_is_crystal(s.cfg.mode) ##1 s.state == ST_EXTERNAL);
    fail_over_c: cover property (s.state == ST_EXTERNAL ##1 s.state == ST_FAILED);
    recover_c: cover property (s.state == ST_FAILED ##1 s.state == ST_STARTUP);

endmodule : scsc_clock_control
`default_nettype wire

// >>> bench/scsc_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far-side oscillator: crystal, resonator or logic-level source
module scsc_osc_model #(
    parameter int HALF = 3
) (
    // Clock and control
    input wire logic clk,
    input wire logic run,
    // Oscillator pin
    output logic ext_clk_pin
);
    logic [7:0] cnt;

    // Idle level at time zero
    initial begin
        ext_clk_pin = 1'b0;
        cnt = 8'h00;
    end

    // Square wave while running, parked low when stopped so a lost clock looks lost
    always @(posedge clk) begin
        if (!run) begin
            ext_clk_pin <= 1'b0;
            cnt <= 8'h00;
        end else if (cnt == 8'(HALF - 1)) begin
            ext_clk_pin <= ~ext_clk_pin; // Logic-level edges only
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : scsc_osc_model
`default_nettype wire

// >>> bench/tb_system_clock_source_control.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the clock source control
module tb_system_clock_source_control;
    import scsc_pkg::*;

    localparam int START_N = 16;
    localparam int FAIL_N = 50;

    logic clk;
    logic reset;
    logic run;
    logic ext_clk_pin;
    scsc_straps_t straps;
    scsc_bus_req_t bus;
    logic [7:0] rd_data;
    scsc_clk_ctl_t clk_ctl;
    logic osc_fail_request;
    int errors;
    int tests_run;

    // Short counts keep the run brief
    scsc_clock_control #(.START_PERIODS(START_N), .FAIL_CYCLES(FAIL_N)) i_scsc_clock_control (
        .clk(clk), .reset(reset), .straps(straps), .ext_clk_pin(ext_clk_pin),
        .bus(bus), .rd_data(rd_data), .clk_ctl(clk_ctl),
        .osc_fail_request(osc_fail_request));

    scsc_osc_model #(.HALF(3)) i_scsc_osc_model (.clk(clk), .run(run),
        .ext_clk_pin(ext_clk_pin));

    // 125 MHz clock
    always #4 clk = ~clk;

    // ==========================================================
    // Helpers
    task automatic finish_test();
        $display("tests %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle strobes, changed right after the edge
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus <= '0;
        #1;
        check(16'(rd_data), 16'(exp));
    endtask : bus_rd

    // Bounded wait on hold_clock (sel 0) or use_internal (sel 1)
    task automatic wait_bit(input int sel, input logic val, input int limit);
        int n;
        n = 0;
        while (((sel == 0) ? clk_ctl.hold_clock : clk_ctl.use_internal) !== val) begin
            @(posedge clk);
            #1;
            n++;
            if (n > limit) begin
                errors++;
                $display("wrong value at %0t: wait timed out", $time);
                finish_test();
            end
        end
    endtask : wait_bit

    // Straps must be settled before release, they are caught once
    task automatic do_reset(input scsc_mode_t m, input logic ts);
        @(posedge clk);
        straps <= '{mode: m, two_speed: ts, fail_safe: 1'b1, clock_out_pin_function: 1'b1};
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask : do_reset

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        run <= 1'b0;
        do_reset(EXT_CLOCK_HIGH_POWER, 1'b0);
        check(16'(clk_ctl.trim), 16'h0000);
        bus_rd(SCSC_REG_CONTROL, 8'h38);
        bus_rd(SCSC_REG_TRIM, 8'h00);
        bus_rd(4'hf, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_ext_modes();
        run <= 1'b1;
        // RC and internal modes first, then the three external clock settings
        for (int m = 3; m <= 7; m++) begin
            do_reset(scsc_mode_t'(m), 1'b0);
            check(16'(clk_ctl.crystal_drive), 16'h0000);
            check(16'(clk_ctl.power), 16'((m >= 5) ? m - 5 : 0));
            check(16'(clk_ctl.clock_out_pin_function_en), 16'h0001);
            wait_bit(1, m == 4, 100);
        end
        $display("test external and internal modes done");
    endtask : t_ext_modes

    task automatic t_software();
        bus_wr(SCSC_REG_CONTROL, 8'h00);
        check(16'(clk_ctl.int_source), 16'(SCSC_INTERNAL_LOW_FREQ_SOURCE));
        bus_wr(SCSC_REG_CONTROL, 8'h08);
        check(16'(clk_ctl.int_source), 16'(SCSC_INTERNAL_MID_FREQ_SOURCE));
        bus_wr(SCSC_REG_CONTROL, 8'hc0);
        check(16'(clk_ctl.int_source), 16'(SCSC_INTERNAL_HIGH_FREQ_SOURCE));
        check(16'(clk_ctl.pll_on), 16'h0000);
        // PLL only runs while the internal block drives the clock
        bus_wr(SCSC_REG_CONTROL, 8'hc2);
        check(16'(clk_ctl.pll_on), 16'h0001);
        bus_wr(SCSC_REG_CONTROL, 8'h3a);
        check(16'(clk_ctl.use_internal), 16'h0001);
        bus_wr(SCSC_REG_CONTROL, 8'h38);
        wait_bit(1, 1'b0, 20);
        bus_wr(SCSC_REG_TRIM, 8'he0);
        check(16'(clk_ctl.trim), 16'h0020);
        bus_rd(SCSC_REG_TRIM, 8'h20);
        bus_wr(SCSC_REG_TRIM, 8'h1f);
        bus_rd(SCSC_REG_TRIM, 8'h1f);
        $display("test software control done");
    endtask : t_software

    task automatic t_crystal();
        run <= 1'b1;
        for (int m = 0; m <= 2; m++) begin
            do_reset(scsc_mode_t'(m), 1'b0);
            check(16'(clk_ctl.crystal_drive), 16'h0001);
            check(16'(clk_ctl.power), 16'(m));
            check(16'(clk_ctl.clock_out_pin_function_en), 16'h0000);
        end
        // Fewer than the start-up count of edges so far: still held
        repeat (50) @(posedge clk);
        #1;
        check(16'(clk_ctl.hold_clock), 16'h0001);
        wait_bit(0, 1'b0, 200);
        wait_bit(1, 1'b0, 10);
        bus_rd(SCSC_REG_STATUS, 8'h50);
        $display("test crystal start-up done");
    endtask : t_crystal

    task automatic t_fail();
        bus_wr(SCSC_REG_FAIL, 8'h02);
        run <= 1'b0;
        wait_bit(1, 1'b1, 300);
        repeat (3) @(posedge clk);
        #1;
        check(16'(osc_fail_request), 16'h0001);
        bus_rd(SCSC_REG_FAIL, 8'h03);
        run <= 1'b1;
        repeat (20) @(posedge clk);
        bus_wr(SCSC_REG_FAIL, 8'h03);
        bus_rd(SCSC_REG_FAIL, 8'h02);
        check(16'(osc_fail_request), 16'h0000);
        $display("test fail-safe done");
    endtask : t_fail

    task automatic t_two_speed();
        run <= 1'b1;
        do_reset(LOW_POWER_CRYSTAL_MODE, 1'b1);
        check(16'(clk_ctl.hold_clock), 16'h0000);
        check(16'(clk_ctl.use_internal), 16'h0001);
        wait_bit(1, 1'b0, 300);
        $display("test two-speed start done");
    endtask : t_two_speed

    // ==========================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        run = 1'b0;
        bus = '0;
        straps = '0;
        errors = 0;
        tests_run = 0;
        t_reset();
        t_ext_modes();
        t_software();
        t_crystal();
        t_fail();
        t_two_speed();
        finish_test();
    end
endmodule : tb_system_clock_source_control
`default_nettype wire
